//--- sic_iic_ctrl.v
// two-wire mode control registers with condition, ack and scl/sda control
// assumes pins are resolved outside from out/oe pairs; the serial channel
// supplies its data bit and transfer clock on the same clock as clk
`include "sic_defines.vh"
module sic_iic_ctrl (
  // system
  input wire clk,
  input wire sys_rst,
  // register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // serial channel side
  input wire chan_data_bit,
  input wire chan_xfer_clk,
  output reg chan_init,
  output reg two_wire_mode,
  output reg two_wire_opt,
  output reg clk_phase_dly,
  output reg clk_stall,
  // bus pins
  input wire scl_in,
  input wire sda_in,
  output reg scl_out,
  output reg scl_oe,
  output reg sda_out,
  output reg sda_oe
);

// ****************************************
// registers
// ****************************************
reg [7:0] cond_ack_ff;
reg [7:0] phase_dly_ff;
reg [7:0] wait_ctl_ff;
reg [7:0] mode_bus_ff;
reg [7:0] baud_div_ff;
reg [7:0] baud_cnt_ff;
reg baud_tick_ff;
reg [2:0] scl_sync_ff;
reg [2:0] sda_sync_ff;
reg scl_flt_ff;
reg sda_flt_ff;
reg [1:0] seq_kind_ff;
reg [1:0] seq_step_ff;
reg seq_scl_ff;
reg seq_sda_ff;
reg [7:0] sda_pipe_ff;

wire wr_cond = reg_wr && (reg_addr == `SIC_OFS_COND_ACK);
wire wr_phase = reg_wr && (reg_addr == `SIC_OFS_PHASE_DLY);
wire wr_wait = reg_wr && (reg_addr == `SIC_OFS_WAIT_CTL);
wire wr_mode = reg_wr && (reg_addr == `SIC_OFS_MODE_BUS);
wire wr_baud = reg_wr && (reg_addr == `SIC_OFS_BAUD_DIV);

wire mode_on = mode_bus_ff[`SIC_B_MODE_SEL];
wire [2:0] dly_sel = phase_dly_ff[`SIC_B_DLY_MSB:`SIC_B_DLY_LSB];

// ****************************************
// baud count source divider
// ****************************************
always @(posedge clk or posedge sys_rst) begin
  if (sys_rst) begin
    baud_cnt_ff <= 8'h00;
    baud_tick_ff <= 1'b0;
  end else if (baud_cnt_ff >= baud_div_ff) begin
    baud_cnt_ff <= 8'h00;
    baud_tick_ff <= 1'b1;
  end else begin
    baud_cnt_ff <= baud_cnt_ff + 8'h01;
    baud_tick_ff <= 1'b0;
  end
end

// ****************************************
// pin input synchronisers and filter
// ****************************************
// a level is taken only once stages two and three agree
always @(posedge clk or posedge sys_rst) begin
  if (sys_rst) begin
    scl_sync_ff <= 3'h7;
    sda_sync_ff <= 3'h7;
    scl_flt_ff <= 1'b1;
    sda_flt_ff <= 1'b1;
  end else begin
    scl_sync_ff <= {scl_sync_ff[1:0], scl_in};
    sda_sync_ff <= {sda_sync_ff[1:0], sda_in};
    if (scl_sync_ff[1] == scl_sync_ff[2]) begin
      scl_flt_ff <= scl_sync_ff[2];
    end
    if (sda_sync_ff[1] == sda_sync_ff[2]) begin
      sda_flt_ff <= sda_sync_ff[2];
    end
  end
end

wire sda_agree = (sda_sync_ff[1] == sda_sync_ff[2]);
wire sda_fall = sda_agree && sda_flt_ff && !sda_sync_ff[2];
wire sda_rise = sda_agree && !sda_flt_ff && sda_sync_ff[2];
// scl must still be high in the oldest stage: an sda edge that lands with
// a falling scl in the same cycle is no condition
wire start_det = scl_flt_ff && scl_sync_ff[2] && sda_fall;
wire stop_det = scl_flt_ff && scl_sync_ff[2] && sda_rise;

// ****************************************
// condition sequencer
// ****************************************
// one step per baud tick; start wins over restart, restart over stop
reg [1:0] nxt_seq_kind;
reg [1:0] nxt_seq_step;
reg nxt_seq_scl;
reg nxt_seq_sda;
reg seq_done;
always @* begin
  nxt_seq_kind = seq_kind_ff;
  nxt_seq_step = seq_step_ff;
  nxt_seq_scl = seq_scl_ff;
  nxt_seq_sda = seq_sda_ff;
  seq_done = 1'b0;
  if (!mode_on) begin
    nxt_seq_kind = `SIC_SEQ_IDLE;
    nxt_seq_step = 2'h0;
  end else if (baud_tick_ff) begin
    case (seq_kind_ff)
      `SIC_SEQ_IDLE: begin
        nxt_seq_step = 2'h0;
        if (cond_ack_ff[`SIC_B_START]) begin
          nxt_seq_kind = `SIC_SEQ_START;
          nxt_seq_scl = 1'b1;
          nxt_seq_sda = 1'b1;
        end else if (cond_ack_ff[`SIC_B_RESTART]) begin
          nxt_seq_kind = `SIC_SEQ_RESTART;
          nxt_seq_scl = 1'b0;
          nxt_seq_sda = 1'b1;
        end else if (cond_ack_ff[`SIC_B_STOP]) begin
          nxt_seq_kind = `SIC_SEQ_STOP;
          nxt_seq_scl = 1'b0;
          nxt_seq_sda = 1'b0;
        end
      end
      `SIC_SEQ_START: begin
        nxt_seq_step = seq_step_ff + 2'h1;
        if (seq_step_ff == 2'h0) begin
          nxt_seq_sda = 1'b0;
        end else begin
          nxt_seq_scl = 1'b0;
          nxt_seq_kind = `SIC_SEQ_IDLE;
          seq_done = 1'b1;
        end
      end
      `SIC_SEQ_RESTART: begin
        nxt_seq_step = seq_step_ff + 2'h1;
        if (seq_step_ff == 2'h0) begin
          nxt_seq_scl = 1'b1;
        end else if (seq_step_ff == 2'h1) begin
          nxt_seq_sda = 1'b0;
        end else begin
          nxt_seq_scl = 1'b0;
          nxt_seq_kind = `SIC_SEQ_IDLE;
          seq_done = 1'b1;
        end
      end
      default: begin
        nxt_seq_step = seq_step_ff + 2'h1;
        // one extra tick so scl stays high after sda rises
        if (seq_step_ff == 2'h0) begin
          nxt_seq_scl = 1'b1;
        end else if (seq_step_ff == 2'h1) begin
          nxt_seq_sda = 1'b1;
        end else begin
          nxt_seq_kind = `SIC_SEQ_IDLE;
          seq_done = 1'b1;
        end
      end
    endcase
  end
end

always @(posedge clk or posedge sys_rst) begin
  if (sys_rst) begin
    seq_kind_ff <= `SIC_SEQ_IDLE;
    seq_step_ff <= 2'h0;
    seq_scl_ff <= 1'b1;
    seq_sda_ff <= 1'b1;
  end else begin
    seq_kind_ff <= nxt_seq_kind;
    seq_step_ff <= nxt_seq_step;
    seq_scl_ff <= nxt_seq_scl;
    seq_sda_ff <= nxt_seq_sda;
  end
end

wire seq_busy = (seq_kind_ff != `SIC_SEQ_IDLE);

// ****************************************
// register writes
// ****************************************
// hardware clears the finished request first so a write in the same
// cycle keeps what software wrote
reg [7:0] nxt_cond_ack;
reg [7:0] nxt_mode_bus;
always @* begin
  nxt_cond_ack = cond_ack_ff;
  if (seq_done) begin
    case (seq_kind_ff)
      `SIC_SEQ_START: nxt_cond_ack[`SIC_B_START] = 1'b0;
      `SIC_SEQ_RESTART: nxt_cond_ack[`SIC_B_RESTART] = 1'b0;
      default: nxt_cond_ack[`SIC_B_STOP] = 1'b0;
    endcase
  end
  if (wr_cond) begin
    nxt_cond_ack = reg_wdata;
  end
  nxt_mode_bus = mode_bus_ff;
  if (wr_mode) begin
    nxt_mode_bus = reg_wdata & `SIC_MASK_MODE;
    // busy can only be cleared by software, never set
    nxt_mode_bus[`SIC_B_BUSY] = mode_bus_ff[`SIC_B_BUSY] &
      reg_wdata[`SIC_B_BUSY];
  end
  if (stop_det) begin
    nxt_mode_bus[`SIC_B_BUSY] = 1'b0;
  end
  if (start_det) begin
    nxt_mode_bus[`SIC_B_BUSY] = 1'b1;
  end
end

always @(posedge clk or posedge sys_rst) begin
  if (sys_rst) begin
    cond_ack_ff <= `SIC_RST_REG;
    phase_dly_ff <= `SIC_RST_REG;
    wait_ctl_ff <= `SIC_RST_REG;
    mode_bus_ff <= `SIC_RST_REG;
    baud_div_ff <= `SIC_RST_BAUD;
  end else begin
    cond_ack_ff <= nxt_cond_ack;
    mode_bus_ff <= nxt_mode_bus;
    if (wr_phase) begin
      phase_dly_ff <= reg_wdata & `SIC_MASK_PHASE;
    end
    if (wr_wait) begin
      wait_ctl_ff <= reg_wdata & `SIC_MASK_WAIT;
    end
    if (wr_baud) begin
      baud_div_ff <= reg_wdata;
    end
  end
end

// ****************************************
// register reads
// ****************************************
always @(posedge clk or posedge sys_rst) begin
  if (sys_rst) begin
    reg_rdata <= 8'h00;
  end else if (reg_rd) begin
    if (reg_addr == `SIC_OFS_COND_ACK) begin
      reg_rdata <= cond_ack_ff;
    end else if (reg_addr == `SIC_OFS_PHASE_DLY) begin
      reg_rdata <= phase_dly_ff;
    end else if (reg_addr == `SIC_OFS_WAIT_CTL) begin
      reg_rdata <= wait_ctl_ff;
    end else if (reg_addr == `SIC_OFS_MODE_BUS) begin
      reg_rdata <= mode_bus_ff;
    end else if (reg_addr == `SIC_OFS_BAUD_DIV) begin
      reg_rdata <= baud_div_ff;
    end else begin
      reg_rdata <= 8'h00;
    end
  end
end

// ****************************************
// sda digital delay
// ****************************************
// tap n of a tick-clocked line: the tick phase gives n to n+1 ticks
wire sda_src = cond_ack_ff[`SIC_B_ACK_SEL] ?
  cond_ack_ff[`SIC_B_ACK_VAL] : chan_data_bit;
always @(posedge clk or posedge sys_rst) begin
  if (sys_rst) begin
    sda_pipe_ff <= 8'hff;
  end else if (baud_tick_ff) begin
    sda_pipe_ff <= {sda_pipe_ff[6:0], sda_src};
  end
end
// a nonzero delay outside two-wire mode is left to software to avoid
wire sda_dly = (dly_sel == 3'h0) ? sda_src :
  sda_pipe_ff[dly_sel];

// ****************************************
// pin drive
// ****************************************
reg nxt_scl;
reg nxt_scl_en;
reg nxt_sda;
reg nxt_sda_en;
reg scl_drv;
always @* begin
  nxt_scl = 1'b1;
  nxt_scl_en = 1'b1;
  nxt_sda = 1'b1;
  nxt_sda_en = 1'b0;
  scl_drv = chan_xfer_clk;
  if (mode_on) begin
    if (seq_busy && cond_ack_ff[`SIC_B_COND_SEL]) begin
      scl_drv = seq_scl_ff;
    end
    if (wait_ctl_ff[`SIC_B_WAIT_EN] && wait_ctl_ff[`SIC_B_WAIT_LOW]) begin
      scl_drv = 1'b0;
    end
    if (cond_ack_ff[`SIC_B_LOW_HOLD]) begin
      scl_drv = 1'b0;
    end
    nxt_scl = scl_drv;
    // open-drain only pulls low, push-pull drives both levels
    nxt_scl_en = phase_dly_ff[`SIC_B_OPEN_DRAIN] ? !scl_drv : 1'b1;
    if (cond_ack_ff[`SIC_B_SCL_HALT]) begin
      nxt_scl_en = 1'b0;
    end
    nxt_sda = sda_dly;
    if (seq_busy && cond_ack_ff[`SIC_B_COND_SEL]) begin
      nxt_sda = seq_sda_ff;
    end
    nxt_sda_en = !nxt_sda;
    if (wait_ctl_ff[`SIC_B_SDA_OFF]) begin
      nxt_sda_en = 1'b0;
    end
  end else begin
    nxt_scl = chan_xfer_clk;
    nxt_scl_en = phase_dly_ff[`SIC_B_OPEN_DRAIN] ?
      !chan_xfer_clk : 1'b1;
  end
end

always @(posedge clk or posedge sys_rst) begin
  if (sys_rst) begin
    scl_out <= 1'b1;
    scl_oe <= 1'b0;
    sda_out <= 1'b1;
    sda_oe <= 1'b0;
    chan_init <= 1'b0;
    two_wire_mode <= 1'b0;
    two_wire_opt <= 1'b0;
    clk_phase_dly <= 1'b0;
    clk_stall <= 1'b0;
  end else begin
    scl_out <= nxt_scl;
    scl_oe <= nxt_scl_en;
    sda_out <= nxt_sda;
    sda_oe <= nxt_sda_en;
    chan_init <= mode_on && wait_ctl_ff[`SIC_B_INIT] && start_det;
    two_wire_mode <= mode_on;
    two_wire_opt <= wait_ctl_ff[`SIC_B_MODE_OPT];
    clk_phase_dly <= phase_dly_ff[`SIC_B_PHASE];
    // released high but bus held low: the channel waits for the bus clock
    clk_stall <= mode_on && wait_ctl_ff[`SIC_B_SYNC] &&
      nxt_scl && !scl_flt_ff;
  end
end

endmodule

//--- sic_defines.vh
// constants for the two-wire mode control register group
// assumes an 8-bit register port and a 250 MHz system clock
//
// Functional notes
// - start, restart, stop request bits start a condition; cleared when done
// - conditions reach the pins only when condition output select is 1
// - sda carries serial data, or the ack value when ack output selected
// - scl output halt enable stops driving scl
// - scl low-hold bit holds scl low while set and scl output halt is clear
// - clock pin drive: push-pull at 0, open-drain at 1
// - sda delay n gives n to n+1 baud ticks, 0 gives none
// - clock sync enable makes scl follow the bus clock
// - scl wait enable; wait force-low selects low or transfer clock
// - channel init enable reinitialises transfer state on start
// - sda output off bit releases sda to high impedance
// - bus busy set on start detect, cleared on stop detect
// - software write 0 clears bus busy, write 1 has no effect
`ifndef SIC_DEFINES_VH
`define SIC_DEFINES_VH
// ****************************************
// register offsets
// ****************************************
`define SIC_OFS_COND_ACK 8'hbc
`define SIC_OFS_PHASE_DLY 8'hbd
`define SIC_OFS_WAIT_CTL 8'hbe
`define SIC_OFS_MODE_BUS 8'hbf
`define SIC_OFS_BAUD_DIV 8'hc0
// ****************************************
// field positions
// ****************************************
`define SIC_B_START 0
`define SIC_B_RESTART 1
`define SIC_B_STOP 2
`define SIC_B_COND_SEL 3
`define SIC_B_ACK_VAL 4
`define SIC_B_ACK_SEL 5
`define SIC_B_SCL_HALT 6
`define SIC_B_LOW_HOLD 7
`define SIC_B_PHASE 1
`define SIC_B_OPEN_DRAIN 3
`define SIC_B_DLY_LSB 5
`define SIC_B_DLY_MSB 7
`define SIC_B_MODE_OPT 0
`define SIC_B_SYNC 1
`define SIC_B_WAIT_EN 2
`define SIC_B_INIT 4
`define SIC_B_WAIT_LOW 5
`define SIC_B_SDA_OFF 6
`define SIC_B_MODE_SEL 0
`define SIC_B_BUSY 2
// ****************************************
// reset values and masks
// ****************************************
`define SIC_RST_REG 8'h00
`define SIC_RST_BAUD 8'h09
`define SIC_MASK_PHASE 8'hea
`define SIC_MASK_WAIT 8'h7f
`define SIC_MASK_MODE 8'h7b
// ****************************************
// condition sequencer
// ****************************************
`define SIC_SEQ_IDLE 2'h0
`define SIC_SEQ_START 2'h1
`define SIC_SEQ_RESTART 2'h2
`define SIC_SEQ_STOP 2'h3
`endif

//--- sic_iic_ctrl_sva.sv
// port checker for the two-wire control register block
// assumes one clock domain; control writes are shadowed from the port
module sic_iic_ctrl_chk (
  // system
  input wire clk,
  input wire sys_rst,
  // register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  // channel and pins
  input wire chan_init,
  input wire two_wire_mode,
  input wire scl_out,
  input wire scl_oe,
  input wire sda_out,
  input wire sda_oe
);
  // ****
  // shadow controls, judged only once 7 clk pass with no write
  // ****
  reg [7:0] c_ff;
  reg [7:0] d_ff;
  reg [7:0] w_ff;
  reg m_ff;
  reg [2:0] calm_ff;
  wire calm = calm_ff == 3'h7;
  wire ok = calm && m_ff;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      c_ff <= 8'h00;
      d_ff <= 8'h00;
      w_ff <= 8'h00;
      m_ff <= 1'b0;
      calm_ff <= 3'h0;
    end else if (reg_wr) begin
      calm_ff <= 3'h0;
      case (reg_addr)
        8'hbc: c_ff <= reg_wdata;
        8'hbd: d_ff <= reg_wdata;
        8'hbe: w_ff <= reg_wdata;
        8'hbf: m_ff <= reg_wdata[0];
        default: ;
      endcase
    end else if (!calm) begin
      calm_ff <= calm_ff + 3'h1;
    end
  end
  // ****
  // pin rules
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  low_hold_a: assert property (
    ok && c_ff[7] && !c_ff[6] |-> scl_oe && !scl_out)
    else $error("scl not held low");
  scl_halt_a: assert property (
    ok && c_ff[6] |-> !scl_oe) else $error("scl driven in halt");
  scl_drain_a: assert property (
    calm && d_ff[3] && !(m_ff && c_ff[6]) |-> scl_oe == !scl_out)
    else $error("scl not open drain");
  sda_off_a: assert property (
    calm && w_ff[6] |-> !sda_oe) else $error("sda driven while off");
  ack_drive_a: assert property (
    ok && c_ff[5] && c_ff[3:0] == 4'h0 && !w_ff[6] && d_ff[7:5] == 3'h0
    |-> sda_out == c_ff[4] && sda_oe == !c_ff[4])
    else $error("sda not ack value");
  mode_off_a: assert property (
    calm && !m_ff |-> !sda_oe) else $error("sda driven in other mode");
  wait_low_a: assert property (
    ok && w_ff[2] && w_ff[5] && !c_ff[6] |-> scl_oe && !scl_out)
    else $error("scl wait not low");
  init_pulse_a: assert property (
    chan_init |=> !chan_init) else $error("init pulse too long");
  mode_copy_a: assert property (
    reg_wr && reg_addr == 8'hbf ##1 !reg_wr [*2] |-> two_wire_mode == m_ff)
    else $error("mode copy wrong");
endmodule
bind sic_iic_ctrl sic_iic_ctrl_chk chk (.clk, .sys_rst, .reg_addr,
  .reg_wdata, .reg_wr, .chan_init, .two_wire_mode, .scl_out, .scl_oe,
  .sda_out, .sda_oe);

//--- sic_bus_dev.sv
// far-side bus device: open-drain pulls on scl and sda
// assumes pull-ups outside; link clock runs only inside a frame
module sic_bus_dev (
  // control from bench
  input wire go,
  input wire hold,
  // pulls, high = line pulled low
  output wire scl_pd,
  output reg sda_pd
);
  timeunit 1ns;
  timeprecision 1ps;
  reg clk_pd;
  // stretching scl low stands in for a slow peer
  assign scl_pd = hold || clk_pd;
  initial begin
    clk_pd = 1'b0;
    sda_pd = 1'b0;
  end
  // frame: start, two link clocks of 32 ns, stop
  always @(posedge go) begin
    sda_pd = 1'b1;
    #16;
    repeat (2) begin
      clk_pd = 1'b1;
      #16;
      clk_pd = 1'b0;
      #16;
    end
    sda_pd = 1'b0;
  end
endmodule

//--- tb_sic_iic_ctrl.sv
// bench for the two-wire control block with a far-side bus device
// assumes pull-ups on scl and sda
module tb_sic_iic_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // signals
  // ****
  logic clk;
  logic sys_rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic cdat;
  logic cxclk;
  logic chan_init;
  logic two_wire_mode;
  logic clk_stall;
  logic scl_out, scl_oe, sda_out, sda_oe;
  logic go;
  logic hold;
  logic ps, pd, topt, cph;
  wire scl_pd;
  wire sda_pd;
  wire scl_w = !scl_pd && (!scl_oe || scl_out);
  wire sda_w = !sda_pd && (!sda_oe || sda_out);
  int error_cnt, comparisons, cyc, starts, stops, inits, i, k;
  logic [7:0] d;
  logic [23:0] r;
  string tname;
  // address, write data, read back
  logic [23:0] rows [9] = '{24'hbcffff, 24'hbc0000, 24'hbd1f0a,
    24'hbd0000, 24'hbeff7f, 24'hbe0000, 24'hbfff7b, 24'hbf0000,
    24'hc7ff00};
  sic_iic_ctrl dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .chan_data_bit(cdat), .chan_xfer_clk(cxclk),
    .chan_init, .two_wire_mode, .two_wire_opt(topt), .clk_phase_dly(cph),
    .clk_stall, .scl_in(scl_w), .sda_in(sda_w), .scl_out, .scl_oe,
    .sda_out, .sda_oe);
  sic_bus_dev dev (.go, .hold, .scl_pd, .sda_pd);
  always #2 clk = ~clk;
  // pins sampled per clock so edges landing together are not miscounted
  always @(posedge clk) begin
    if (scl_w && ps && pd && !sda_w) starts++;
    if (scl_w && ps && !pd && sda_w) stops++;
    ps <= scl_w;
    pd <= sda_w;
  end
  always @(posedge clk) begin
    if (chan_init === 1'b1) inits++;
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      wrap_up;
    end
  end
  // ****
  // tasks
  // ****
  task chk(input logic [7:0] s, input logic [7:0] e);
    begin
      comparisons++;
      if (s !== e) begin
        error_cnt++;
        $display("Error %s exp %h seen %h", tname, e, s);
      end
    end
  endtask
  task chb(input logic b, input logic e);
    chk({7'h00, b}, {7'h00, e});
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] v);
    begin
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
    end
  endtask
  task put(input logic [7:0] a, input logic [7:0] v);
    begin
      wr_reg(a, v);
      repeat (8) @(posedge clk);
    end
  endtask
  task rd_reg(input logic [7:0] a);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      d = reg_rdata;
    end
  endtask
  task rchk(input logic [7:0] a, input logic [7:0] e);
    begin
      rd_reg(a);
      chk(d, e);
    end
  endtask
  // polls until the request bits clear, bounded
  task wait_clr(input logic [7:0] m);
    begin
      k = 0;
      d = m;
      while ((d & m) != 8'h00 && k < 40) begin
        rd_reg(8'hbc);
        k++;
      end
    end
  endtask
  task wrap_up;
    begin
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // ****
  // sequence
  // ****
  initial begin
    clk = 1'b0;
    sys_rst <= 1'b1;
    reg_addr <= 8'h00;
    reg_wdata <= 8'h00;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    cdat <= 1'b1;
    cxclk <= 1'b1;
    go <= 1'b0;
    hold <= 1'b0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    tname = "reset";
    for (i = 0; i < 4; i++) rchk(8'hbc + i[7:0], 8'h00);
    rchk(8'hc0, 8'h09);
    tname = "regs";
    for (i = 0; i < 9; i++) begin
      r = rows[i];
      wr_reg(r[23:16], r[15:8]);
      rchk(r[23:16], r[7:0]);
    end
    $display("done regs");
    tname = "conditions";
    starts = 0;
    stops = 0;
    cxclk <= 1'b0;
    wr_reg(8'hc0, 8'h01);
    wr_reg(8'hbf, 8'h01);
    wr_reg(8'hbc, 8'h09);
    wait_clr(8'h01);
    chk(d, 8'h08);
    chk(starts[7:0], 8'h01);
    rchk(8'hbf, 8'h05);
    wr_reg(8'hbc, 8'h0a);
    wait_clr(8'h02);
    chk(d, 8'h08);
    chk(starts[7:0], 8'h02);
    wr_reg(8'hbc, 8'h0c);
    wait_clr(8'h04);
    chk(stops[7:0], 8'h01);
    rchk(8'hbf, 8'h01);
    wr_reg(8'hbc, 8'h01);
    wait_clr(8'h01);
    chk(d, 8'h00);
    chk(starts[7:0], 8'h02);
    wr_reg(8'hbf, 8'h00);
    put(8'hbc, 8'h01);
    rchk(8'hbc, 8'h01);
    wr_reg(8'hbc, 8'h00);
    $display("done conditions");
    tname = "bus busy";
    cxclk <= 1'b1;
    wr_reg(8'hbf, 8'h01);
    wr_reg(8'hbe, 8'h10);
    for (i = 0; i < 2; i++) begin
      go <= 1'b1;
      repeat (6) @(posedge clk);
      rchk(8'hbf, 8'h05);
      if (i == 1) begin
        wr_reg(8'hbf, 8'h01);
        rchk(8'hbf, 8'h01);
      end
      go <= 1'b0;
      repeat (30) @(posedge clk);
      rchk(8'hbf, 8'h01);
    end
    chk(inits[7:0], 8'h02);
    $display("done bus busy");
    tname = "scl";
    put(8'hbe, 8'h02);
    hold <= 1'b1;
    repeat (8) @(posedge clk);
    chb(clk_stall, 1'b1);
    hold <= 1'b0;
    repeat (8) @(posedge clk);
    chb(clk_stall, 1'b0);
    put(8'hbe, 8'h24);
    chb(scl_w, 1'b0);
    put(8'hbe, 8'h20);
    chb(scl_w, 1'b1);
    wr_reg(8'hbe, 8'h00);
    put(8'hbc, 8'h80);
    chb(scl_w, 1'b0);
    put(8'hbc, 8'h40);
    chb(scl_oe, 1'b0);
    wr_reg(8'hbc, 8'h00);
    put(8'hbd, 8'h08);
    chb(scl_oe, 1'b0);
    put(8'hbd, 8'h00);
    chb(scl_oe, 1'b1);
    $display("done scl");
    tname = "sda";
    put(8'hbc, 8'h20);
    chb(sda_w, 1'b0);
    put(8'hbe, 8'h40);
    chb(sda_w, 1'b1);
    put(8'hbe, 8'h00);
    cdat <= 1'b0;
    put(8'hbc, 8'h30);
    chb(sda_w, 1'b1);
    // delay n spans n to n+1 ticks of 2 clk, plus a short pipeline
    for (i = 0; i < 8; i++) begin
      wr_reg(8'hbd, {i[2:0], 5'h00});
      put(8'hbc, 8'h20);
      repeat (12) @(posedge clk);
      wr_reg(8'hbc, 8'h30);
      k = 0;
      while (sda_out !== 1'b1 && k < 60) begin
        @(posedge clk);
        k++;
      end
      chb(k >= 2 * i + 1 && k <= 2 * i + 3 && (i == 0 || k >= 2 * i + 2),
        1'b1);
    end
    wr_reg(8'hbd, 8'h00);
    $display("done sda");
    tname = "copies";
    put(8'hbe, 8'h01);
    chb(topt, 1'b1);
    put(8'hbd, 8'h02);
    chb(cph, 1'b1);
    wr_reg(8'hbd, 8'h00);
    $display("done copies");
    wrap_up;
  end
endmodule
